// *** inc/tile_dp_pkg.sv ***
// constants for the logic tile datapath and its status and control registers
package tile_dp_pkg;
    // ==========================================
    // register indices on the system bus
    localparam logic [4:0] IDX_ACC0 = 5'h00;
    localparam logic [4:0] IDX_ACC1 = 5'h01;
    localparam logic [4:0] IDX_OPR0 = 5'h02;
    localparam logic [4:0] IDX_OPR1 = 5'h03;
    localparam logic [4:0] IDX_QUEUE0 = 5'h04;
    localparam logic [4:0] IDX_QUEUE1 = 5'h05;
    localparam logic [4:0] IDX_STATIC = 5'h06;
    localparam logic [4:0] IDX_ORMASK = 5'h07;
    localparam logic [4:0] IDX_CMPMASK = 5'h08;
    localparam logic [4:0] IDX_POLY = 5'h09;
    localparam logic [4:0] IDX_OUTSEL_LO = 5'h0A;
    localparam logic [4:0] IDX_OUTSEL_HI = 5'h0B;
    localparam logic [4:0] IDX_CONTROL = 5'h0C;
    localparam logic [4:0] IDX_STATUS = 5'h0D;
    localparam logic [4:0] IDX_LATCH_EN = 5'h0E;
    localparam logic [4:0] IDX_CFG_BASE = 5'h10;
    // ==========================================
    // dynamic configuration word fields
    localparam int CF_FUNC = 0;
    localparam int CF_SRCA = 3;
    localparam int CF_SRCB = 4;
    localparam int CF_SHIFT = 6;
    localparam int CF_ORMASK = 8;
    localparam int CF_DEST = 9;
    localparam int CF_QPUSH = 11;
    localparam int CF_QPOP = 12;
    localparam int CF_CRC = 13;
    localparam int CF_CIN = 14;
    // ==========================================
    // static configuration fields
    localparam int SC_MSB = 0;
    localparam int SC_Q0_OUT = 3;
    localparam int SC_Q1_OUT = 4;
    localparam int SC_QCAP_ACC = 5;
    localparam int SC_QPOP_OPR = 6;
    localparam int SC_CMP0_ACC1 = 7;
    localparam int SC_CMP1_OPR0 = 8;
    localparam int SC_SIN = 9;
    localparam int SC_CHAIN_CMP = 11;
    localparam int SC_DP_EN = 12;
    localparam int SC_SC_EN = 14;
    localparam logic [15:0] STATIC_RST = 16'h5000;
    // ==========================================
    // alu functions, shift modes, carry and shift sources, enable sources
    localparam logic [2:0] FN_INC = 3'h0;
    localparam logic [2:0] FN_DEC = 3'h1;
    localparam logic [2:0] FN_ADD = 3'h2;
    localparam logic [2:0] FN_SUB = 3'h3;
    localparam logic [2:0] FN_AND = 3'h4;
    localparam logic [2:0] FN_OR = 3'h5;
    localparam logic [2:0] FN_XOR = 3'h6;
    localparam logic [2:0] FN_PASS = 3'h7;
    localparam logic [1:0] SH_NONE = 2'h0;
    localparam logic [1:0] SH_LEFT = 2'h1;
    localparam logic [1:0] SH_RIGHT = 2'h2;
    localparam logic [1:0] SH_SWAP = 2'h3;
    localparam logic [1:0] SRC_ZERO = 2'h0;
    localparam logic [1:0] SRC_ONE = 2'h1;
    localparam logic [1:0] SRC_REG = 2'h2;
    localparam logic [1:0] SRC_CHAIN = 2'h3;
    localparam logic [1:0] EN_OFF = 2'h0;
    localparam logic [1:0] EN_ON = 2'h1;
    localparam logic [1:0] EN_FABRIC = 2'h2;
    localparam logic [1:0] EN_CTL = 2'h3;
    localparam int QDEPTH = 4;
    localparam int NCOND = 16;
endpackage

// *** hdl/tile_datapath.sv ***
// logic tile datapath with working registers, queues, config ram, status and control
// Operation
// - six working registers, all reachable from the system bus
// - accumulators are alu sources, alu destinations and compare operands
// - data registers are alu and compare sources, never alu destinations
// - each queue holds four bytes, loads registers or captures accumulators or alu
// - eight 16-bit configuration words; the selected word sets this cycle's function
// - alu does increment, decrement, add, subtract, and, or, xor, pass
// - result optionally shifted left, right or nibble-swapped, then optionally or-masked
// - two comparators with bit masks over accumulators and data registers
// - zero, all-ones and overflow conditions; selected conditions go to fabric
// - programmable most significant bit for arithmetic and shifts
// - one crc or pseudo-random step per cycle, programmable polynomial and width
// - each queue independently set as input or output buffer
// - queue status selectable onto fabric outputs
// - carry, shift data and a condition pass to and from neighbours
// - carry out and shift out registered, selectable as later inputs
// - six fabric inputs and six fabric outputs
// - control register bits drive the fabric
// - read-only status register shows fabric signals
// - status bits can latch until software reads the status register
// - datapath and status-control each have their own enable source
// - eight-bit operands, one operation per clock
`timescale 1ns/1ps
`default_nettype none
module tile_datapath (
    input wire logic core_clk, // 125 MHz clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic [4:0] bus_addr, // register index
    input wire logic bus_wr, // write strobe
    input wire logic bus_rd, // read strobe
    input wire logic [15:0] bus_wdata, // write data
    output logic [15:0] bus_rdata, // read data, one cycle after bus_rd
    input wire logic [5:0] fab_in, // config address, serial in, enable
    output logic [5:0] fab_out, // selected conditions
    output logic [7:0] ctl_out, // control bits into the fabric
    input wire logic [7:0] status_in, // fabric signals for the status register
    input wire logic chain_carry_in, // carry from neighbour
    input wire logic chain_shift_in, // shift data from neighbour
    input wire logic chain_cond_in, // compare condition from neighbour
    output logic chain_carry_out, // carry to neighbour
    output logic chain_shift_out, // shift data to neighbour
    output logic chain_cond_out // compare condition to neighbour
);
    // ==========================================
    // functions
    function automatic logic [7:0] width_mask(input logic [2:0] m);
        width_mask = 8'hFF >> (3'h7 - m);
    endfunction

    function automatic logic en_pick(input logic [1:0] s, input logic f, input logic c);
        case (s)
            tile_dp_pkg::EN_OFF: en_pick = 1'b0;
            tile_dp_pkg::EN_ON: en_pick = 1'b1;
            tile_dp_pkg::EN_FABRIC: en_pick = f;
            default: en_pick = c;
        endcase
    endfunction

    function automatic logic src_pick(input logic [1:0] s, input logic r, input logic c);
        case (s)
            tile_dp_pkg::SRC_ZERO: src_pick = 1'b0;
            tile_dp_pkg::SRC_ONE: src_pick = 1'b1;
            tile_dp_pkg::SRC_REG: src_pick = r;
            default: src_pick = c;
        endcase
    endfunction

    // ==========================================
    // registers
    logic [7:0] acc_reg [2];
    logic [7:0] opr_reg [2];
    logic [15:0] cfg_ram [8];
    logic [15:0] static_reg, cmpmask_reg, outsel_lo_reg, outsel_hi_reg;
    logic [7:0] ormask_reg, poly_reg, ctl_reg, stat_reg, sticky_reg, latch_en_reg;
    logic carry_reg, shout_reg;
    logic [7:0] q_head [2];
    logic [1:0] q_empty, q_full, q_out_mode, q_bus_push, q_bus_pop, q_dp_push, q_dp_pop;

    logic [15:0] cw;
    logic [2:0] msb;
    logic [7:0] wm, opa, opb, bx, alu_r, sh_r, res;
    logic [8:0] sum9;
    logic dp_en, sc_en, cin, sin, carry_next, shout, ovf, arith, fb;
    logic eq0, lt0, eq1, lt1;
    logic [7:0] c0l, c0r, c1l, c1r;
    localparam int NCOND_W = tile_dp_pkg::NCOND;
    logic [NCOND_W-1:0] cond;

    assign dp_en = en_pick(static_reg[tile_dp_pkg::SC_DP_EN +: 2], fab_in[5], ctl_reg[0]);
    assign sc_en = en_pick(static_reg[tile_dp_pkg::SC_SC_EN +: 2], fab_in[5], ctl_reg[0]);
    assign cw = cfg_ram[fab_in[2:0]];
    assign msb = static_reg[tile_dp_pkg::SC_MSB +: 3];
    assign wm = width_mask(msb);
    assign q_out_mode = {static_reg[tile_dp_pkg::SC_Q1_OUT], static_reg[tile_dp_pkg::SC_Q0_OUT]};

    // ==========================================
    // alu, shifter and mask
    always_comb begin
        opa = cw[tile_dp_pkg::CF_SRCA] ? acc_reg[1] : acc_reg[0];
        case (cw[tile_dp_pkg::CF_SRCB +: 2])
            2'h0: opb = opr_reg[0];
            2'h1: opb = opr_reg[1];
            2'h2: opb = acc_reg[0];
            default: opb = acc_reg[1];
        endcase
        cin = src_pick(cw[tile_dp_pkg::CF_CIN +: 2], carry_reg, chain_carry_in);
        sin = src_pick(static_reg[tile_dp_pkg::SC_SIN +: 2], shout_reg,
            chain_shift_in) | (static_reg[tile_dp_pkg::SC_SIN +: 2] == 2'h0 && fab_in[3]);
        arith = 1'b1;
        case (cw[tile_dp_pkg::CF_FUNC +: 3])
            tile_dp_pkg::FN_INC: bx = 8'h01;
            tile_dp_pkg::FN_DEC: bx = 8'hFF;
            tile_dp_pkg::FN_ADD: bx = opb;
            tile_dp_pkg::FN_SUB: bx = ~opb;
            default: begin
                bx = 8'h00;
                arith = 1'b0;
            end
        endcase
        // operands are cut at the msb so the carry emerges just above it
        bx = bx & wm;
        sum9 = {1'b0, opa & wm} + {1'b0, bx} +
            {8'h00, cin & (cw[tile_dp_pkg::CF_FUNC +: 3] inside {tile_dp_pkg::FN_ADD,
            tile_dp_pkg::FN_SUB})};
        case (cw[tile_dp_pkg::CF_FUNC +: 3])
            tile_dp_pkg::FN_AND: alu_r = opa & opb;
            tile_dp_pkg::FN_OR: alu_r = opa | opb;
            tile_dp_pkg::FN_XOR: alu_r = opa ^ opb;
            tile_dp_pkg::FN_PASS: alu_r = opa;
            default: alu_r = sum9[7:0] & wm;
        endcase
        carry_next = arith ? sum9[4'(msb) + 4'h1] : carry_reg;
        ovf = arith && (opa[msb] == bx[msb]) && (alu_r[msb] != opa[msb]);
        fb = alu_r[msb] ^ sin;
        shout = 1'b0;
        case (cw[tile_dp_pkg::CF_SHIFT +: 2])
            tile_dp_pkg::SH_LEFT: begin
                if (cw[tile_dp_pkg::CF_CRC]) begin
                    // one lfsr step: feedback folds the polynomial in
                    sh_r = ((alu_r << 1) ^ (fb ? poly_reg : 8'h00)) & wm;
                    shout = fb;
                end else begin
                    sh_r = ((alu_r << 1) | {7'h00, sin}) & wm;
                    shout = alu_r[msb];
                end
            end
            tile_dp_pkg::SH_RIGHT: begin
                sh_r = (alu_r >> 1) | ({7'h00, sin} << msb);
                shout = alu_r[0];
            end
            tile_dp_pkg::SH_SWAP: sh_r = {alu_r[3:0], alu_r[7:4]};
            default: sh_r = alu_r;
        endcase
        res = cw[tile_dp_pkg::CF_ORMASK] ? (sh_r | ormask_reg) : sh_r;
    end

    // ==========================================
    // comparators and conditions
    always_comb begin
        c0l = acc_reg[0] & cmpmask_reg[7:0];
        c0r = (static_reg[tile_dp_pkg::SC_CMP0_ACC1] ? acc_reg[1] : opr_reg[0]) & cmpmask_reg[7:0];
        c1l = acc_reg[1] & cmpmask_reg[15:8];
        c1r = (static_reg[tile_dp_pkg::SC_CMP1_OPR0] ? opr_reg[0] : opr_reg[1]) & cmpmask_reg[15:8];
        eq0 = (c0l == c0r) & (chain_cond_in | ~static_reg[tile_dp_pkg::SC_CHAIN_CMP]);
        lt0 = c0l < c0r;
        eq1 = c1l == c1r;
        lt1 = c1l < c1r;
        cond = {1'b0, shout_reg, q_full[1], q_empty[1], q_full[0], q_empty[0], carry_reg, ovf,
            (acc_reg[1] & wm) == wm, (acc_reg[0] & wm) == wm, acc_reg[1] == 8'h00,
            acc_reg[0] == 8'h00, lt1, eq1, lt0, eq0};
    end

    // fabric outputs pick any condition through a four-bit selector each
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_out
            logic [3:0] sel;
            assign sel = (gi < 4) ? outsel_lo_reg[4*(gi%4) +: 4] : outsel_hi_reg[4*(gi%4) +: 4];
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    fab_out[gi] <= 1'b0;
                end else if (dp_en) begin
                    fab_out[gi] <= cond[sel];
                end
            end
        end
    endgenerate

    // ==========================================
    // queues
    generate
        for (gi = 0; gi < 2; gi++) begin : g_q
            logic [7:0] mem [tile_dp_pkg::QDEPTH];
            logic [1:0] wp, rp;
            logic [2:0] cnt;
            logic push, pop;
            logic [7:0] din;
            logic [4:0] qidx;
            assign qidx = gi ? tile_dp_pkg::IDX_QUEUE1 : tile_dp_pkg::IDX_QUEUE0;
            assign q_empty[gi] = cnt == 3'h0;
            assign q_full[gi] = cnt == 3'(tile_dp_pkg::QDEPTH);
            assign q_head[gi] = mem[rp];
            assign q_bus_push[gi] = bus_wr && bus_addr == qidx && !q_out_mode[gi] && !q_full[gi];
            assign q_bus_pop[gi] = bus_rd && bus_addr == qidx && q_out_mode[gi] && !q_empty[gi];
            assign q_dp_push[gi] = dp_en && cw[tile_dp_pkg::CF_QPUSH] && q_out_mode[gi] &&
                !q_full[gi];
            assign q_dp_pop[gi] = dp_en && cw[tile_dp_pkg::CF_QPOP] && !q_out_mode[gi] &&
                !q_empty[gi];
            assign push = q_bus_push[gi] | q_dp_push[gi];
            assign pop = q_bus_pop[gi] | q_dp_pop[gi];
            assign din = q_out_mode[gi] ?
                (static_reg[tile_dp_pkg::SC_QCAP_ACC] ? acc_reg[gi] : res) : bus_wdata[7:0];
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    wp <= 2'h0;
                    rp <= 2'h0;
                    cnt <= 3'h0;
                end else begin
                    if (push) begin
                        mem[wp] <= din;
                        wp <= wp + 2'h1;
                    end
                    if (pop) begin
                        rp <= rp + 2'h1;
                    end
                    cnt <= cnt + {2'h0, push} - {2'h0, pop};
                end
            end
        end
    endgenerate

    // ==========================================
    // working registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            acc_reg[0] <= 8'h00;
            acc_reg[1] <= 8'h00;
            opr_reg[0] <= 8'h00;
            opr_reg[1] <= 8'h00;
        end else begin
            if (dp_en && cw[tile_dp_pkg::CF_DEST]) begin
                acc_reg[0] <= res;
            end
            if (dp_en && cw[tile_dp_pkg::CF_DEST + 1]) begin
                acc_reg[1] <= res;
            end
            for (int i = 0; i < 2; i++) begin
                if (q_dp_pop[i] && static_reg[tile_dp_pkg::SC_QPOP_OPR]) begin
                    opr_reg[i] <= q_head[i];
                end else if (q_dp_pop[i]) begin
                    acc_reg[i] <= q_head[i];
                end
            end
            // software writes take priority over the datapath in the same cycle
            if (bus_wr) begin
                case (bus_addr)
                    tile_dp_pkg::IDX_ACC0: acc_reg[0] <= bus_wdata[7:0];
                    tile_dp_pkg::IDX_ACC1: acc_reg[1] <= bus_wdata[7:0];
                    tile_dp_pkg::IDX_OPR0: opr_reg[0] <= bus_wdata[7:0];
                    tile_dp_pkg::IDX_OPR1: opr_reg[1] <= bus_wdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            carry_reg <= 1'b0;
            shout_reg <= 1'b0;
            chain_carry_out <= 1'b0;
            chain_shift_out <= 1'b0;
            chain_cond_out <= 1'b0;
        end else if (dp_en) begin
            carry_reg <= carry_next;
            shout_reg <= shout;
            chain_carry_out <= carry_next;
            chain_shift_out <= shout;
            chain_cond_out <= eq0;
        end
    end

    // ==========================================
    // configuration registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            static_reg <= tile_dp_pkg::STATIC_RST;
            cmpmask_reg <= 16'hFFFF;
            outsel_lo_reg <= 16'h0000;
            outsel_hi_reg <= 16'h0000;
            ormask_reg <= 8'h00;
            poly_reg <= 8'h00;
            latch_en_reg <= 8'h00;
            ctl_reg <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                cfg_ram[i] <= 16'h0000;
            end
        end else if (bus_wr) begin
            case (bus_addr)
                tile_dp_pkg::IDX_STATIC: static_reg <= bus_wdata;
                tile_dp_pkg::IDX_CMPMASK: cmpmask_reg <= bus_wdata;
                tile_dp_pkg::IDX_OUTSEL_LO: outsel_lo_reg <= bus_wdata;
                tile_dp_pkg::IDX_OUTSEL_HI: outsel_hi_reg <= bus_wdata;
                tile_dp_pkg::IDX_ORMASK: ormask_reg <= bus_wdata[7:0];
                tile_dp_pkg::IDX_POLY: poly_reg <= bus_wdata[7:0];
                tile_dp_pkg::IDX_LATCH_EN: latch_en_reg <= bus_wdata[7:0];
                tile_dp_pkg::IDX_CONTROL: ctl_reg <= bus_wdata[7:0];
                default: begin
                    if (bus_addr[4:3] == tile_dp_pkg::IDX_CFG_BASE[4:3]) begin
                        cfg_ram[bus_addr[2:0]] <= bus_wdata;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // status and control module
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctl_out <= 8'h00;
            stat_reg <= 8'h00;
            sticky_reg <= 8'h00;
        end else begin
            if (sc_en) begin
                ctl_out <= ctl_reg;
                stat_reg <= status_in;
            end
            // a set arriving with the clearing read survives it
            sticky_reg <= ((bus_rd && bus_addr == tile_dp_pkg::IDX_STATUS) ? 8'h00 : sticky_reg)
                | (sc_en ? (status_in & latch_en_reg) : 8'h00);
        end
    end

    // ==========================================
    // bus read
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bus_rdata <= 16'h0000;
        end else if (bus_rd) begin
            case (bus_addr)
                tile_dp_pkg::IDX_ACC0: bus_rdata <= {8'h00, acc_reg[0]};
                tile_dp_pkg::IDX_ACC1: bus_rdata <= {8'h00, acc_reg[1]};
                tile_dp_pkg::IDX_OPR0: bus_rdata <= {8'h00, opr_reg[0]};
                tile_dp_pkg::IDX_OPR1: bus_rdata <= {8'h00, opr_reg[1]};
                tile_dp_pkg::IDX_QUEUE0: bus_rdata <= {8'h00, q_bus_pop[0] ? q_head[0] : 8'h00};
                tile_dp_pkg::IDX_QUEUE1: bus_rdata <= {8'h00, q_bus_pop[1] ? q_head[1] : 8'h00};
                tile_dp_pkg::IDX_STATIC: bus_rdata <= static_reg;
                tile_dp_pkg::IDX_CMPMASK: bus_rdata <= cmpmask_reg;
                tile_dp_pkg::IDX_OUTSEL_LO: bus_rdata <= outsel_lo_reg;
                tile_dp_pkg::IDX_OUTSEL_HI: bus_rdata <= outsel_hi_reg;
                tile_dp_pkg::IDX_ORMASK: bus_rdata <= {8'h00, ormask_reg};
                tile_dp_pkg::IDX_POLY: bus_rdata <= {8'h00, poly_reg};
                tile_dp_pkg::IDX_LATCH_EN: bus_rdata <= {8'h00, latch_en_reg};
                tile_dp_pkg::IDX_CONTROL: bus_rdata <= {8'h00, ctl_reg};
                tile_dp_pkg::IDX_STATUS: bus_rdata <= {6'h00, q_full[1] | q_full[0],
                    q_empty[1] & q_empty[0], 8'h00} | {8'h00,
                    (stat_reg & ~latch_en_reg) | (sticky_reg & latch_en_reg)};
                default: bus_rdata <= (bus_addr[4:3] == tile_dp_pkg::IDX_CFG_BASE[4:3]) ?
                    cfg_ram[bus_addr[2:0]] : 16'h0000;
            endcase
        end
    end
endmodule // tile_datapath
`default_nettype wire

// *** tb/tile_dp_properties.sv ***
// bus and control port checker for the logic tile datapath
`timescale 1ns/1ps
`default_nettype none
module tile_dp_properties (
    input wire logic core_clk, // clock
    input wire logic nrst, // sync reset, active low
    input wire logic [4:0] bus_addr, // register index
    input wire logic bus_wr, // write strobe
    input wire logic bus_rd, // read strobe
    input wire logic [15:0] bus_wdata, // write data
    input wire logic [15:0] bus_rdata, // read data
    input wire logic [7:0] ctl_out // control bits
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire wc = bus_wr && bus_addr == tile_dp_pkg::IDX_CONTROL;
    logic [7:0] last_ctl;
    // control copy may lag the write by one extra cycle, so keep the value written
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            last_ctl <= 8'h00;
        end else if (wc) begin
            last_ctl <= bus_wdata[7:0];
        end
    end
    // ==========================================
    // bus side
    a_reset_zero: assert property (disable iff (1'b0) !nrst |=> bus_rdata == 16'h0000 && ctl_out == 8'h00)
        else $error("outputs not cleared by reset");
    a_rdata_holds: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (bus_rd && bus_addr == 5'h0F |=> bus_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_narrow_regs: assert property (bus_rd && bus_addr <= tile_dp_pkg::IDX_OPR1 |=> bus_rdata[15:8] == 8'h00)
        else $error("working register wider than a byte");
    a_status_upper: assert property (bus_rd && bus_addr == tile_dp_pkg::IDX_STATUS |=> bus_rdata[15:10] == 6'h00)
        else $error("status upper bits set");
    a_opr_readback: assert property (bus_wr && bus_addr == tile_dp_pkg::IDX_OPR0 ##1 !bus_wr ##1 bus_rd && bus_addr == tile_dp_pkg::IDX_OPR0 |=> bus_rdata[7:0] == $past(bus_wdata[7:0], 3))
        else $error("data register lost its write");
    a_cfg_readback: assert property (bus_wr && bus_addr == tile_dp_pkg::IDX_CFG_BASE ##1 !bus_wr ##1 bus_rd && bus_addr == tile_dp_pkg::IDX_CFG_BASE |=> bus_rdata == $past(bus_wdata, 3))
        else $error("config word lost its write");
    // ==========================================
    // control side
    a_ctl_write: assert property (wc ##1 !wc |-> ##[0:1] ctl_out == last_ctl)
        else $error("control write not driven out");
    a_ctl_quiet: assert property ($past(nrst) && $changed(ctl_out) |-> $past(wc) || $past(wc, 2))
        else $error("control bits moved without a write");
endmodule // tile_dp_properties
bind tile_datapath tile_dp_properties tile_dp_properties_i (.core_clk, .nrst, .bus_addr, .bus_wr,
    .bus_rd, .bus_wdata, .bus_rdata, .ctl_out);
`default_nettype wire

// *** tb/fabric_model.sv ***
// routing fabric stand-in: sequences the config address, loops control back to status
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
    input wire logic step, // run the chosen word for one cycle
    input wire logic [2:0] word, // config word for that cycle
    input wire logic [5:0] fab_out, // datapath conditions
    input wire logic [7:0] ctl_out, // control bits
    output logic [5:0] fab_in, // config address and serial data
    output logic [7:0] status_in, // signals to status register
    output logic chain_carry_in, // neighbour carry
    output logic chain_shift_in, // neighbour shift data
    output logic chain_cond_in // neighbour condition
);
    // idle on word 1, left blank, so the accumulators stay put between operations
    assign fab_in = {3'h0, step ? word : 3'h1};
    assign status_in = {fab_out, ctl_out[1:0]};
    assign chain_carry_in = 1'b0;
    assign chain_shift_in = 1'b0;
    assign chain_cond_in = 1'b1;
endmodule // fabric_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the logic tile datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_top;
    typedef struct {logic [15:0] cfg; logic [7:0] a; logic [7:0] b; logic [7:0] exp;} row_t;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] bus_addr = 5'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [15:0] bus_wdata = 16'h0000;
    logic [15:0] bus_rdata, rd_val;
    logic step = 1'b0;
    logic [2:0] word = 3'h0;
    logic [5:0] fab_in, fab_out;
    logic [7:0] ctl_out, status_in;
    logic chain_carry_in, chain_shift_in, chain_cond_in, chain_cond_out;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    // ==========================================
    // alu functions, shifts and or-mask on acc0 with opr0, result back to acc0
    row_t rows[12] = '{'{16'h0200, 8'h7F, 8'h00, 8'h80}, '{16'h0201, 8'h00, 8'h00, 8'hFF},
        '{16'h0202, 8'h70, 8'h25, 8'h95}, '{16'h4203, 8'h50, 8'h21, 8'h2F},
        '{16'h0204, 8'hF0, 8'h3C, 8'h30}, '{16'h0205, 8'hF0, 8'h3C, 8'hFC},
        '{16'h0206, 8'hF0, 8'h3C, 8'hCC}, '{16'h0207, 8'h3C, 8'h3C, 8'h3C},
        '{16'h0246, 8'hF0, 8'h3C, 8'h98}, '{16'h0286, 8'hF0, 8'h3C, 8'h66},
        '{16'h02C4, 8'hF0, 8'h3C, 8'h03}, '{16'h0304, 8'hF0, 8'h3C, 8'hB0}};
    tile_datapath tile_datapath_i (.core_clk, .nrst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
        .bus_rdata, .fab_in, .fab_out, .ctl_out, .status_in, .chain_carry_in, .chain_shift_in,
        .chain_cond_in, .chain_carry_out(), .chain_shift_out(), .chain_cond_out);
    fabric_model fabric_model_i (.step, .word, .fab_out, .ctl_out, .fab_in, .status_in,
        .chain_carry_in, .chain_shift_in, .chain_cond_in);
    always #4 core_clk = ~core_clk;
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(negedge core_clk);
        bus_wr = w;
        bus_rd = !w;
        bus_addr = a;
        bus_wdata = d;
        @(negedge core_clk);
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        rd_val = bus_rdata;
    endtask
    task automatic run(input logic [2:0] n);
        @(negedge core_clk);
        word = n;
        step = 1'b1;
        @(negedge core_clk);
        step = 1'b0;
    endtask
    task automatic test_done;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            test_done;
        end
    end
    initial begin
        repeat (3) @(negedge core_clk);
        nrst = 1'b1;
        `CHK(ctl_out, 8'h00)
        acc(1'b0, tile_dp_pkg::IDX_STATIC, 16'h0000);
        `CHK(rd_val, tile_dp_pkg::STATIC_RST)
        acc(1'b1, tile_dp_pkg::IDX_STATIC, 16'h5007);
        acc(1'b1, tile_dp_pkg::IDX_ORMASK, 16'h0080);
        foreach (rows[i]) begin
            acc(1'b1, tile_dp_pkg::IDX_OPR0, {8'h00, rows[i].b});
            acc(1'b1, tile_dp_pkg::IDX_ACC0, {8'h00, rows[i].a});
            acc(1'b1, tile_dp_pkg::IDX_CFG_BASE, rows[i].cfg);
            run(3'h0);
            acc(1'b0, tile_dp_pkg::IDX_ACC0, 16'h0000);
            `CHK(rd_val[7:0], rows[i].exp)
        end
        // ==========================================
        // readback, unmapped, control and status
        acc(1'b1, tile_dp_pkg::IDX_OPR0, 16'h005A);
        acc(1'b0, tile_dp_pkg::IDX_OPR0, 16'h0000);
        `CHK(rd_val, 16'h005A)
        acc(1'b1, tile_dp_pkg::IDX_CFG_BASE, 16'hA5C3);
        acc(1'b0, tile_dp_pkg::IDX_CFG_BASE, 16'h0000);
        `CHK(rd_val, 16'hA5C3)
        acc(1'b0, 5'h0F, 16'h0000);
        `CHK(rd_val, 16'h0000)
        acc(1'b1, tile_dp_pkg::IDX_CONTROL, 16'h0002);
        acc(1'b1, tile_dp_pkg::IDX_LATCH_EN, 16'h0000);
        `CHK(ctl_out, 8'h02)
        acc(1'b0, tile_dp_pkg::IDX_STATUS, 16'h0000);
        `CHK(rd_val[9:0] & 10'h303, 10'h102)
        acc(1'b1, tile_dp_pkg::IDX_LATCH_EN, 16'h0001);
        acc(1'b1, tile_dp_pkg::IDX_CONTROL, 16'h0001);
        acc(1'b1, tile_dp_pkg::IDX_CONTROL, 16'h0000);
        acc(1'b1, tile_dp_pkg::IDX_LATCH_EN, 16'h0001);
        acc(1'b0, tile_dp_pkg::IDX_STATUS, 16'h0000);
        `CHK(rd_val[0], 1'b1)
        acc(1'b0, tile_dp_pkg::IDX_STATUS, 16'h0000);
        `CHK(rd_val[0], 1'b0)
        // ==========================================
        // input queue: overfill, refused read, drain past empty
        for (int k = 1; k <= 5; k++) begin
            acc(1'b1, tile_dp_pkg::IDX_QUEUE0, 16'(k * 8'h11));
        end
        acc(1'b0, tile_dp_pkg::IDX_STATUS, 16'h0000);
        `CHK(rd_val[9], 1'b1)
        acc(1'b0, tile_dp_pkg::IDX_QUEUE0, 16'h0000);
        `CHK(rd_val, 16'h0000)
        acc(1'b1, tile_dp_pkg::IDX_CFG_BASE, 16'h1000);
        repeat (5) run(3'h0);
        acc(1'b0, tile_dp_pkg::IDX_ACC0, 16'h0000);
        `CHK(rd_val[7:0], 8'h44)
        acc(1'b0, tile_dp_pkg::IDX_STATUS, 16'h0000);
        `CHK(rd_val[9:8], 2'b01)
        // acc0 made equal to opr0; outputs are registered one edge later
        acc(1'b1, tile_dp_pkg::IDX_ACC0, 16'h005A);
        @(negedge core_clk);
        `CHK(fab_out, 6'h3F)
        `CHK(chain_cond_out, 1'b1)
        test_done;
    end
endmodule // tb_top
`default_nettype wire
